/* rtl/drt_pkg.sv */
// Purpose: Shared constants and the state type of the dual rank transceiver.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Control pin indices describe the synchronised control vector.
package drt_pkg;

    // ------------------------------------------------------------
    // Data and pin layout
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int CTL_W = 10;
    localparam int CTL_DRIVE_B_N = 0;
    localparam int CTL_DRIVE_A_N = 1;
    localparam int CTL_CLK_A = 2;
    localparam int CTL_CLK_B = 3;
    localparam int CTL_EN_A_N = 4;
    localparam int CTL_EN_B_N = 5;
    localparam int CTL_GA_HI = 6;
    localparam int CTL_GA_LO_N = 7;
    localparam int CTL_GB_HI = 8;
    localparam int CTL_GB_LO_N = 9;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LOG = 8'h08;
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_LOG_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_RANK_A_LSB = 0;
    localparam int STAT_RANK_B_LSB = 8;
    localparam int STAT_OE_A_N_BIT = 16;
    localparam int STAT_OE_B_N_BIT = 17;
    localparam int STAT_COUNT_LSB = 18;
    localparam int LOG_ID_BIT = 8;
    localparam int LOG_VALID_BIT = 31;
    localparam logic [7:0] RANK_RESET = 8'h00;

    // ------------------------------------------------------------
    // Whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTL_W-1:0] ctl_s1;
        logic [CTL_W-1:0] ctl_s2;
        logic [DATA_W-1:0] a_s1;
        logic [DATA_W-1:0] a_s2;
        logic [DATA_W-1:0] b_s1;
        logic [DATA_W-1:0] b_s2;
        logic [1:0] clk_prev;
        logic [DATA_W-1:0] rank_a;
        logic [DATA_W-1:0] rank_b;
        logic [DATA_W-1:0] a_out;
        logic [DATA_W-1:0] b_out;
        logic a_oe_n;
        logic b_oe_n;
        logic [1:0] ctrl;
        logic [1:0][DATA_W:0] log_mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } drt_state_t;

endpackage : drt_pkg

/* rtl/drt_xcvr.sv */
// Purpose: Dual rank 8-bit bus register/latch transceiver with an APB slave.
// Assumes: All bus and control pins are asynchronous to pclk and pass two flip-flops first.
// Notes: In register mode, ranks load at the pclk edge after a synchronised rank clock rises.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module drt_xcvr
    import drt_pkg::*;
#(
    parameter bit INVERT_OUT = 1'b0
) (
    input wire logic pclk,                         // APB and core clock
    input wire logic presetn,                      // Async reset, active low
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB access phase
    input wire logic pwrite,                       // APB write
    input wire logic [7:0] paddr,                  // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    output logic [31:0] prdata,                    // APB read data
    output logic pready,                           // APB ready
    output logic pslverr,                          // APB error, unmapped address
    input wire logic drive_b_side_n,               // Output control toward B
    input wire logic drive_a_side_n,               // Output control toward A
    input wire logic rank_a_clock,                 // Rank A clock
    input wire logic rank_b_clock,                 // Rank B clock
    input wire logic rank_a_load_en_n,             // Rank A clock enable
    input wire logic rank_b_load_en_n,             // Rank B clock enable
    input wire logic rank_a_gate_hi,               // Rank A gate, high active
    input wire logic rank_a_gate_lo_n,             // Rank A gate, low active
    input wire logic rank_b_gate_hi,               // Rank B gate, high active
    input wire logic rank_b_gate_lo_n,             // Rank B gate, low active
    input wire logic [DATA_W-1:0] a_side_port_in,  // A bus level
    output logic [DATA_W-1:0] a_side_port_out,     // A bus drive value
    output logic a_side_port_oe_n,                 // A bus enable, low drives
    input wire logic [DATA_W-1:0] b_side_port_in,  // B bus level
    output logic [DATA_W-1:0] b_side_port_out,     // B bus drive value
    output logic b_side_port_oe_n                  // B bus enable, low drives
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] polarity(input logic [DATA_W-1:0] d);
        polarity = INVERT_OUT ? ~d : d;
    endfunction : polarity

    function automatic logic rank_loads(input logic latch_mode, input logic rise, input logic en_n,
                                        input logic g_hi, input logic g_lo_n);
        rank_loads = latch_mode ? (g_hi | ~g_lo_n) : (rise & ~en_n);
    endfunction : rank_loads

    drt_state_t q;
    drt_state_t d;
    logic [CTL_W-1:0] ctl_pins;
    logic [CTL_W-1:0] c;
    logic rise_a;
    logic rise_b;
    logic log_room;
    logic load_a;
    logic load_b;
    logic [DATA_W-1:0] src_a;
    logic [DATA_W-1:0] src_b;
    logic setup;
    logic done;

    assign ctl_pins = {rank_b_gate_lo_n, rank_b_gate_hi, rank_a_gate_lo_n, rank_a_gate_hi,
                       rank_b_load_en_n, rank_a_load_en_n, rank_b_clock, rank_a_clock,
                       drive_a_side_n, drive_b_side_n};
    assign c = q.ctl_s2;
    assign rise_a = c[CTL_CLK_A] & ~q.clk_prev[0];
    assign rise_b = c[CTL_CLK_B] & ~q.clk_prev[1];
    // Loads are dropped while the capture log is enabled and not empty, so that
    // a slow reader loses no captured word; the rank holds meanwhile.
    assign log_room = ~q.ctrl[CTRL_LOG_EN_BIT] | (q.count == 2'd0);
    assign load_a = log_room & rank_loads(q.ctrl[CTRL_LATCH_BIT], rise_a, c[CTL_EN_A_N],
                                          c[CTL_GA_HI], c[CTL_GA_LO_N]);
    assign load_b = log_room & rank_loads(q.ctrl[CTRL_LATCH_BIT], rise_b, c[CTL_EN_B_N],
                                          c[CTL_GB_HI], c[CTL_GB_LO_N]);
    // Each rank from its own bus
    assign src_a = q.a_oe_n ? q.a_s2 : q.a_out;
    assign src_b = q.b_oe_n ? q.b_s2 : q.b_out;
    assign setup = psel & ~penable;
    assign done = psel & penable & q.ack;

    assign pready = penable & q.ack;
    assign pslverr = penable & q.ack & q.err;
    assign prdata = q.rdata;
    assign a_side_port_out = q.a_out;
    assign a_side_port_oe_n = q.a_oe_n;
    assign b_side_port_out = q.b_out;
    assign b_side_port_oe_n = q.b_oe_n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] pushes;
        logic pop;
        logic ptr;
        pushes = 2'd0;
        pop = 1'b0;
        ptr = q.wr_ptr;
        d = q;
        d.ctl_s1 = ctl_pins;
        d.ctl_s2 = q.ctl_s1;
        d.a_s1 = a_side_port_in;
        d.a_s2 = q.a_s1;
        d.b_s1 = b_side_port_in;
        d.b_s2 = q.b_s1;
        d.clk_prev = {c[CTL_CLK_B], c[CTL_CLK_A]};
        if (load_a) begin
            d.rank_a = src_a;
        end
        if (load_b) begin
            d.rank_b = src_b;
        end
        d.b_oe_n = c[CTL_DRIVE_B_N];
        d.a_oe_n = c[CTL_DRIVE_A_N];
        d.b_out = polarity(d.rank_a);
        d.a_out = polarity(d.rank_b);
        if (q.ctrl[CTRL_LOG_EN_BIT] && !q.ctrl[CTRL_LATCH_BIT]) begin
            if (load_a) begin
                d.log_mem[ptr] = {1'b0, src_a};
                ptr = ~ptr;
                pushes = pushes + 2'd1;
            end
            if (load_b) begin
                d.log_mem[ptr] = {1'b1, src_b};
                ptr = ~ptr;
                pushes = pushes + 2'd1;
            end
        end
        d.wr_ptr = ptr;
        d.ack = 1'b0;
        if (setup) begin
            d.ack = 1'b1;
            d.err = 1'b0;
            d.rdata = 32'h0000_0000;
            if (paddr == ADDR_CTRL) begin
                d.rdata[1:0] = q.ctrl;
            end else if (paddr == ADDR_STATUS) begin
                d.rdata[STAT_RANK_A_LSB +: DATA_W] = q.rank_a;
                d.rdata[STAT_RANK_B_LSB +: DATA_W] = q.rank_b;
                d.rdata[STAT_OE_A_N_BIT] = q.a_oe_n;
                d.rdata[STAT_OE_B_N_BIT] = q.b_oe_n;
                d.rdata[STAT_COUNT_LSB +: 2] = q.count;
            end else if (paddr == ADDR_LOG) begin
                d.rdata[LOG_VALID_BIT] = (q.count != 2'd0);
                d.rdata[DATA_W:0] = (q.count != 2'd0) ? q.log_mem[q.rd_ptr] : 9'h000;
            end else begin
                d.err = 1'b1;
            end
        end
        if (done && pwrite && paddr == ADDR_CTRL) begin
            d.ctrl = pwdata[1:0];
        end
        if (done && !pwrite && paddr == ADDR_LOG && q.count != 2'd0) begin
            pop = 1'b1;
            d.rd_ptr = ~q.rd_ptr;
        end
        d.count = q.count + pushes - {1'b0, pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctl_s1 <= 10'h3ff;
            q.ctl_s2 <= 10'h3ff;
            q.clk_prev <= 2'h3;
            q.rank_a <= RANK_RESET;
            q.rank_b <= RANK_RESET;
            // Outputs start as the driven image of the reset ranks, so the
            // crosswise relation already holds at the first edge after release.
            q.a_out <= {DATA_W{INVERT_OUT}} ^ RANK_RESET;
            q.b_out <= {DATA_W{INVERT_OUT}} ^ RANK_RESET;
            q.a_oe_n <= 1'b1;
            q.b_oe_n <= 1'b1;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ab_direction: assert property (
        (!c[CTL_DRIVE_B_N] && c[CTL_DRIVE_A_N]) |=> (!b_side_port_oe_n && a_side_port_oe_n))
        else $error("A-to-B direction not set");

    a_ba_direction: assert property (
        (c[CTL_DRIVE_B_N] && !c[CTL_DRIVE_A_N]) |=> (b_side_port_oe_n && !a_side_port_oe_n))
        else $error("B-to-A direction not set");

    a_both_inputs: assert property (
        (c[CTL_DRIVE_B_N] && c[CTL_DRIVE_A_N]) |=> (a_side_port_oe_n && b_side_port_oe_n))
        else $error("Buses not released in storage");

    a_both_driven: assert property (
        (!c[CTL_DRIVE_B_N] && !c[CTL_DRIVE_A_N]) |=> (!a_side_port_oe_n && !b_side_port_oe_n))
        else $error("Buses not both driven");

    a_cross_data: assert property (
        ##1 (b_side_port_out == polarity(q.rank_a) && a_side_port_out == polarity(q.rank_b)))
        else $error("Driven data does not match crossed ranks");

    a_reg_capture: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_a && !c[CTL_EN_A_N])
        |=> (q.rank_a == $past(src_a)))
        else $error("Rank A missed an enabled edge");

    a_enable_blocks: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && c[CTL_EN_B_N]) |=> $stable(q.rank_b))
        else $error("Rank B loaded with enable high");

    a_rank_hold: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && !rise_a) |=> $stable(q.rank_a))
        else $error("Rank A changed without an edge");

    a_latch_pass: assert property (
        (q.ctrl[CTRL_LATCH_BIT] && log_room && (c[CTL_GB_HI] || !c[CTL_GB_LO_N]))
        |=> (q.rank_b == $past(src_b)))
        else $error("Open latch B did not pass data");

    a_latch_pass_a: assert property (
        (q.ctrl[CTRL_LATCH_BIT] && log_room && (c[CTL_GA_HI] || !c[CTL_GA_LO_N]))
        |=> (q.rank_a == $past(src_a)))
        else $error("Open latch A did not pass data");

    a_latch_hold_a: assert property (
        (q.ctrl[CTRL_LATCH_BIT] && !c[CTL_GA_HI] && c[CTL_GA_LO_N]) |=> $stable(q.rank_a))
        else $error("Closed latch A changed");

    a_latch_hold_b: assert property (
        (q.ctrl[CTRL_LATCH_BIT] && !c[CTL_GB_HI] && c[CTL_GB_LO_N]) |=> $stable(q.rank_b))
        else $error("Closed latch B changed");

    a_latch_unlogged: assert property (
        q.ctrl[CTRL_LATCH_BIT] |=> (q.count <= $past(q.count)))
        else $error("Latch mode load entered the log");

    // ------------------------------------------------------------
    // Rank register and capture log checks
    // ------------------------------------------------------------
    // A load that the log holds off must leave both ranks alone, or a slow
    // reader would find a word that the rank no longer carries.

    a_reg_capture_b: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_b && !c[CTL_EN_B_N])
        |=> (q.rank_b == $past(src_b)))
        else $error("Rank B missed an enabled edge");

    a_enable_blocks_a: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && c[CTL_EN_A_N]) |=> $stable(q.rank_a))
        else $error("Rank A loaded with enable high");

    a_rank_hold_b: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && !rise_b) |=> $stable(q.rank_b))
        else $error("Rank B changed without an edge");

    a_ranks_apart: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && rise_a && !rise_b) |=> $stable(q.rank_b))
        else $error("Rank B moved with a rank A edge");

    a_store_a: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_a && !c[CTL_EN_A_N] && q.a_oe_n)
        |=> (q.rank_a == $past(q.a_s2)))
        else $error("Rank A did not store the A bus");

    a_store_b: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_b && !c[CTL_EN_B_N] && q.b_oe_n)
        |=> (q.rank_b == $past(q.b_s2)))
        else $error("Rank B did not store the B bus");

    a_swap_a: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_a && !c[CTL_EN_A_N] && !q.a_oe_n)
        |=> (q.rank_a == polarity($past(q.rank_b))))
        else $error("Rank A did not take the driven rank B");

    a_swap_b: assert property (
        (!q.ctrl[CTRL_LATCH_BIT] && log_room && rise_b && !c[CTL_EN_B_N] && !q.b_oe_n)
        |=> (q.rank_b == polarity($past(q.rank_a))))
        else $error("Rank B did not take the driven rank A");

    a_log_holdoff: assert property (
        (q.ctrl[CTRL_LOG_EN_BIT] && q.count != 2'd0) |=> ($stable(q.rank_a) && $stable(q.rank_b)))
        else $error("Rank loaded while the log was waiting");

    a_log_bound: assert property (
        q.count != 2'd3)
        else $error("Capture log count out of range");

    a_log_pop: assert property (
        (psel && penable && pready && !pwrite && paddr == ADDR_LOG && q.count == 2'd1)
        |=> (q.count == 2'd0))
        else $error("Log read did not remove the last entry");

    // ------------------------------------------------------------
    // Bus output checks
    // ------------------------------------------------------------

    a_a_polarity: assert property (
        !a_side_port_oe_n |-> ((a_side_port_out ^ q.rank_b) == {DATA_W{INVERT_OUT}}))
        else $error("A bus data has the wrong polarity");

    a_b_polarity: assert property (
        !b_side_port_oe_n |-> ((b_side_port_out ^ q.rank_a) == {DATA_W{INVERT_OUT}}))
        else $error("B bus data has the wrong polarity");

    a_a_release: assert property (
        $changed(c[CTL_DRIVE_A_N]) |=> $changed(a_side_port_oe_n))
        else $error("A bus enable did not follow its control");

    a_b_release: assert property (
        $changed(c[CTL_DRIVE_B_N]) |=> $changed(b_side_port_oe_n))
        else $error("B bus enable did not follow its control");

endmodule : drt_xcvr

`default_nettype wire

/* tb/drt_far_side.sv */
// Purpose: Far-side logic that shares the A and B buses.
// Assumes: It always offers a value and yields whenever the device drives.
// Notes: The resolved levels feed the transceiver's bus inputs.
`timescale 1ns/1ps
`default_nettype none
module drt_far_side (
    input wire logic [7:0] a_val,  // Value offered on A
    input wire logic [7:0] b_val,  // Value offered on B
    input wire logic [7:0] a_dev,  // Device drive value on A
    input wire logic a_dev_oe_n,   // Device drives A when low
    input wire logic [7:0] b_dev,  // Device drive value on B
    input wire logic b_dev_oe_n,   // Device drives B when low
    output logic [7:0] a_wire,     // Resolved A bus
    output logic [7:0] b_wire      // Resolved B bus
);
    // Yielding avoids a fight that would leave the level undefined.
    always_comb begin
        a_wire = !a_dev_oe_n ? a_dev : a_val;
        b_wire = !b_dev_oe_n ? b_dev : b_val;
    end
endmodule : drt_far_side
`default_nettype wire

/* tb/drt_xcvr_bench.sv */
// Purpose: Self-checking bench for the dual rank transceiver.
// Assumes: Eight clocks let any pin change pass the synchronisers.
// Notes: Built as the inverting variant; the model inverts likewise.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module drt_xcvr_bench
    import drt_pkg::*;
;
    localparam bit INV = 1'b1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, ex;
    logic latch = 1'b0, log_en = 1'b0;
    logic drive_b_side_n = 1'b1, drive_a_side_n = 1'b1;
    logic rank_a_clock = 1'b0, rank_b_clock = 1'b0;
    logic rank_a_load_en_n = 1'b1, rank_b_load_en_n = 1'b1;
    logic rank_a_gate_hi = 1'b0, rank_b_gate_hi = 1'b0;
    logic rank_a_gate_lo_n = 1'b1, rank_b_gate_lo_n = 1'b1;
    logic [7:0] a_in, a_out, b_in, b_out, a_val = 8'h00, b_val = 8'h00, ra = 8'h00, rb = 8'h00;
    logic a_oe_n, b_oe_n;
    logic [31:0] q[$];
    int bad_count = 0;
    int checks = 0;

    drt_xcvr #(.INVERT_OUT(INV)) drt_xcvr_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .drive_b_side_n, .drive_a_side_n, .rank_a_clock, .rank_b_clock, .rank_a_load_en_n,
        .rank_b_load_en_n, .rank_a_gate_hi, .rank_a_gate_lo_n, .rank_b_gate_hi, .rank_b_gate_lo_n,
        .a_side_port_in(a_in), .a_side_port_out(a_out), .a_side_port_oe_n(a_oe_n),
        .b_side_port_in(b_in), .b_side_port_out(b_out), .b_side_port_oe_n(b_oe_n)
    );
    drt_far_side drt_far_side_i (
        .a_val, .b_val, .a_dev(a_out), .a_dev_oe_n(a_oe_n), .b_dev(b_out), .b_dev_oe_n(b_oe_n),
        .a_wire(a_in), .b_wire(b_in)
    );

    always #12.5 pclk = ~pclk;

    // --------------------------------------------------------
    // Model and bus tasks
    // --------------------------------------------------------
    task automatic results();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    function automatic logic [7:0] pol(input logic [7:0] v);
        return INV ? ~v : v;
    endfunction : pol

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            results();
        end
        @(posedge pclk);
    endtask : apb

    task automatic check_all();
        repeat (8) @(posedge pclk);
        `CHK("a_oe_n", drive_a_side_n, a_oe_n)
        `CHK("b_oe_n", drive_b_side_n, b_oe_n)
        if (!drive_a_side_n) `CHK("a_out", pol(rb), a_out)
        if (!drive_b_side_n) `CHK("b_out", pol(ra), b_out)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("rank_a", ra, rd[7:0])
        `CHK("rank_b", rb, rd[15:8])
        `CHK("count", 2'(q.size()), rd[19:18])
    endtask : check_all

    task automatic pulse(input logic ca, input logic cb);
        logic [7:0] na, nb;
        na = ra;
        nb = rb;
        if (!latch && !(log_en && q.size() != 0)) begin
            if (ca && !rank_a_load_en_n) na = !drive_a_side_n ? pol(rb) : a_val;
            if (cb && !rank_b_load_en_n) nb = !drive_b_side_n ? pol(ra) : b_val;
            if (log_en && ca && !rank_a_load_en_n) q.push_back({24'h800000, na});
            if (log_en && cb && !rank_b_load_en_n) q.push_back({24'h800001, nb});
        end
        rank_a_clock <= ca;
        rank_b_clock <= cb;
        repeat (4) @(posedge pclk);
        rank_a_clock <= 1'b0;
        rank_b_clock <= 1'b0;
        ra = na;
        rb = nb;
        check_all();
    endtask : pulse

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        void'($urandom(33));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("slverr", 1'b1, er)
        for (int m = 0; m < 4; m++) begin
            {drive_b_side_n, drive_a_side_n} <= m[1:0];
            check_all();
        end
        a_val <= 8'($urandom);
        b_val <= 8'($urandom);
        rank_a_load_en_n <= 1'b0;
        repeat (8) @(posedge pclk);
        pulse(1'b1, 1'b1);
        a_val <= 8'($urandom);
        rank_b_load_en_n <= 1'b0;
        repeat (8) @(posedge pclk);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b0);
        {drive_b_side_n, drive_a_side_n} <= 2'b00;
        repeat (8) @(posedge pclk);
        pulse(1'b1, 1'b1);
        // buses released before any gate opens
        {drive_b_side_n, drive_a_side_n} <= 2'b11;
        apb(1'b1, ADDR_CTRL, 32'h1);
        latch = 1'b1;
        a_val <= 8'($urandom);
        rank_a_gate_hi <= 1'b1;
        rank_b_gate_lo_n <= 1'b0;
        repeat (8) @(posedge pclk);
        ra = a_val;
        rb = b_val;
        check_all();
        rank_a_gate_hi <= 1'b0;
        rank_b_gate_lo_n <= 1'b1;
        repeat (8) @(posedge pclk);
        a_val <= ~a_val;
        b_val <= ~b_val;
        check_all();
        apb(1'b1, ADDR_CTRL, 32'h2);
        latch = 1'b0;
        log_en = 1'b1;
        pulse(1'b1, 1'b1);
        a_val <= 8'($urandom);
        repeat (8) @(posedge pclk);
        pulse(1'b1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ADDR_LOG, 32'h0);
            ex = q.size() != 0 ? q.pop_front() : 32'h0;
            `CHK("log", ex, rd)
        end
        results();
    end
endmodule : drt_xcvr_bench
`default_nettype wire
